/* led_fault_supervisor.sv */
// Fault supervisor for a three-string LED driver with a boost controller
`timescale 1ns/1ps
module led_fault_supervisor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic string_short_sense_low_i,
    input wire logic string_short_sense_high_i,
    input wire logic anode_feedback_over_i,
    input wire logic anode_feedback_under_i,
    input wire logic cathode_feedback_low_i,
    input wire logic thermistor_sense_low_i,
    input wire logic die_overtemp_shutdown_i,
    input wire logic supply_undervoltage_lockout_i,
    input wire logic led_on_i,
    input wire logic soft_start_done_i,
    input wire logic aux_channel_off_i,
    input wire logic delay_grounded_i,
    output logic shutdown_o,
    output logic standby_o,
    output logic restart_o,
    output logic delay_charge_o,
    output logic delay_discharge_o,
    output logic short_clamp_o,
    output logic [19:0] delay_level_o
);

    // Raw pin inputs gathered for the synchroniser
    logic [led_fault_pkg::NIN-1:0] pin_raw;
    // Three synchroniser stages
    logic [led_fault_pkg::NIN-1:0] sync1_q, sync2_q, sync3_q;
    // Filtered pin levels
    logic [led_fault_pkg::NIN-1:0] pin_q;

    assign pin_raw = {delay_grounded_i, aux_channel_off_i, soft_start_done_i, led_on_i,
                      supply_undervoltage_lockout_i, die_overtemp_shutdown_i,
                      thermistor_sense_low_i, cathode_feedback_low_i,
                      anode_feedback_under_i, anode_feedback_over_i,
                      string_short_sense_high_i, string_short_sense_low_i};

    // Per-pin three-stage synchroniser, level accepted once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < led_fault_pkg::NIN; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    pin_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        pin_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // Named views of the filtered pins
    logic str_low, str_high, fb_over, fb_under, cath_low, therm_low, die_hot, supply_low;
    logic led_on, ss_done, aux_off, dly_gnd;
    assign str_low = pin_q[0];
    assign str_high = pin_q[1];
    assign fb_over = pin_q[2];
    assign fb_under = pin_q[3];
    assign cath_low = pin_q[4];
    assign therm_low = pin_q[5];
    assign die_hot = pin_q[6];
    assign supply_low = pin_q[7];
    assign led_on = pin_q[8];
    assign ss_done = pin_q[9];
    assign aux_off = pin_q[10];
    assign dly_gnd = pin_q[11];

    // Software-set compare points of the delay ramp
    logic [led_fault_pkg::LVL_W-1:0] shut_lvl_q, ceil_lvl_q, restart_lvl_q;
    // Delay ramp level
    logic [led_fault_pkg::LVL_W-1:0] level_q, level_d;
    // Supervisor state
    led_fault_pkg::sup_state_e state_q, state_d;
    // Auto-restart mode captured at startup
    logic auto_q;
    // Cathode short latched at end of soft start
    logic cath_q;
    // Previous soft-start-done level for edge detection
    logic ss_done_q;
    // Previous LED phase for turn-on detection
    logic led_on_q;
    // Blanking counter after LED turn-on
    logic [led_fault_pkg::BLANK_W-1:0] blank_q;
    // Restart pulse register
    logic restart_q;
    // Sticky event bits
    logic [led_fault_pkg::EV_W-1:0] event_q;
    // Bus handshake
    logic ack_q;
    logic [31:0] rdat_q;

    // Fault classification signals
    logic blanked, led_sense, type1, type2_now, type2, type3, charge_on, dis_on;
    logic shut_hit, do_restart;

    // Blanking counter, reloaded at each LED turn-on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_on_q <= 1'b0;
            blank_q <= '0;
        end else begin
            led_on_q <= led_on;
            if (led_on && !led_on_q) begin
                blank_q <= led_fault_pkg::BLANK_W'(led_fault_pkg::BLANK_CYC);
            end else if (blank_q != '0) begin
                blank_q <= blank_q - 1'b1;
            end
        end
    end

    // Fault sensing and grouping
    always_comb begin
        blanked = (blank_q != '0) || (led_on && !led_on_q);
        // Short-sense faults seen only in the LED-on phase after blanking
        led_sense = led_on && !blanked;
        type1 = led_sense && str_low && !str_high;
        // Anode faults are watched in both dimming phases
        type2_now = fb_over || fb_under || (led_sense && str_high);
        type2 = type2_now || cath_q;
        type3 = supply_low || die_hot || therm_low;
        // Charge during on phase for any fault, any time for anode faults
        charge_on = (fb_over || fb_under) || (led_on && (type1 || type2));
        // Discharge only in the on phase with every fault removed
        dis_on = led_on && !blanked && !type1 && !type2 && !str_high;
        shut_hit = type2 && !dly_gnd && (level_q >= shut_lvl_q);
    end

    // Next state and delay ramp model
    always_comb begin
        state_d = state_q;
        level_d = level_q;
        do_restart = 1'b0;
        if (type3) begin
            // Standby overrides every other response
            state_d = led_fault_pkg::S_STANDBY;
            level_d = '0;
        end else begin
            unique case (state_q)
                led_fault_pkg::S_STANDBY: begin
                    // Condition cleared, restart from soft start
                    state_d = led_fault_pkg::S_RUN;
                    do_restart = 1'b1;
                end
                led_fault_pkg::S_RUN: begin
                    if (dly_gnd) begin
                        // Node held at ground, ramp cannot rise
                        level_d = '0;
                    end else if (shut_hit) begin
                        if (!auto_q) begin
                            state_d = led_fault_pkg::S_SHUT;
                            level_d = ceil_lvl_q;
                        end else begin
                            level_d = shut_lvl_q;
                            state_d = fb_over ? led_fault_pkg::S_AUTO_WAIT
                                               : led_fault_pkg::S_AUTO_DIS;
                        end
                    end else if (charge_on) begin
                        // Charge, saturating at the ceiling
                        if (level_q >= ceil_lvl_q - led_fault_pkg::CHARGE_STEP) begin
                            level_d = ceil_lvl_q;
                        end else begin
                            level_d = level_q + led_fault_pkg::CHARGE_STEP;
                        end
                    end else if (dis_on) begin
                        // Discharge, saturating at zero
                        if (level_q <= led_fault_pkg::SINK_STEP) begin
                            level_d = '0;
                        end else begin
                            level_d = level_q - led_fault_pkg::SINK_STEP;
                        end
                    end
                end
                led_fault_pkg::S_SHUT: begin
                    // Latched until standby
                    level_d = ceil_lvl_q;
                end
                led_fault_pkg::S_AUTO_WAIT: begin
                    // Held at shutdown level while over-voltage lasts
                    level_d = shut_lvl_q;
                    if (!fb_over) begin
                        state_d = led_fault_pkg::S_AUTO_DIS;
                    end
                end
                led_fault_pkg::S_AUTO_DIS: begin
                    if (level_q <= restart_lvl_q + led_fault_pkg::SINK_STEP) begin
                        // Restart level reached, soft start again
                        level_d = restart_lvl_q;
                        state_d = led_fault_pkg::S_RUN;
                        do_restart = 1'b1;
                    end else begin
                        level_d = level_q - led_fault_pkg::SINK_STEP;
                    end
                end
                default: begin
                    state_d = led_fault_pkg::S_STANDBY;
                end
            endcase
        end
    end

    // State and ramp registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= led_fault_pkg::S_STANDBY;
            level_q <= '0;
            restart_q <= 1'b0;
        end else begin
            state_q <= state_d;
            level_q <= level_d;
            restart_q <= do_restart;
        end
    end

    // Auto-restart mode captured when leaving standby
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_q <= 1'b0;
        end else if (state_q == led_fault_pkg::S_STANDBY && !type3) begin
            auto_q <= !aux_off;
        end
    end

    // Cathode short latch, set at end of soft start, kept until shutdown or standby
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ss_done_q <= 1'b0;
            cath_q <= 1'b0;
        end else begin
            ss_done_q <= ss_done;
            if (state_q != led_fault_pkg::S_RUN || shut_hit) begin
                cath_q <= 1'b0;
            end else if (ss_done && !ss_done_q && cath_low) begin
                cath_q <= 1'b1;
            end
        end
    end

    // Outputs
    always_comb begin
        shutdown_o = (state_q == led_fault_pkg::S_SHUT) ||
                     (state_q == led_fault_pkg::S_AUTO_WAIT) ||
                     (state_q == led_fault_pkg::S_AUTO_DIS);
        standby_o = (state_q == led_fault_pkg::S_STANDBY);
        restart_o = restart_q;
        delay_charge_o = (state_q == led_fault_pkg::S_RUN) && charge_on && !dly_gnd;
        delay_discharge_o = ((state_q == led_fault_pkg::S_RUN) && !charge_on && dis_on) ||
                            (state_q == led_fault_pkg::S_AUTO_DIS);
        // Clamp only while regulating through a single-string fault
        short_clamp_o = (state_q == led_fault_pkg::S_RUN) && type1;
        delay_level_o = level_q;
    end

    // Bus access signals
    logic bus_req, wr_go;
    logic [31:0] sel_mask;
    assign bus_req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge that sees ack high
    assign wr_go = bus_req && wb_we_i && ack_q;
    assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Merge byte lanes into a stored level
    function automatic logic [led_fault_pkg::LVL_W-1:0] merge(
        input logic [led_fault_pkg::LVL_W-1:0] old_v
    );
        logic [31:0] wide;
        wide = ({12'h000, old_v} & ~sel_mask) | (wb_dat_i & sel_mask);
        return wide[led_fault_pkg::LVL_W-1:0];
    endfunction

    // Compare-point registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shut_lvl_q <= led_fault_pkg::SHUT_LVL_RST;
            ceil_lvl_q <= led_fault_pkg::CEIL_LVL_RST;
            restart_lvl_q <= led_fault_pkg::RESTART_LVL_RST;
        end else if (wr_go) begin
            if (wb_adr_i == led_fault_pkg::SHUT_LVL_OFS) begin
                shut_lvl_q <= merge(shut_lvl_q);
            end
            if (wb_adr_i == led_fault_pkg::CEIL_LVL_OFS) begin
                ceil_lvl_q <= merge(ceil_lvl_q);
            end
            if (wb_adr_i == led_fault_pkg::RESTART_LVL_OFS) begin
                restart_lvl_q <= merge(restart_lvl_q);
            end
        end
    end

    // Sticky events, write one to clear, a new event wins over the clear
    logic [led_fault_pkg::EV_W-1:0] ev_set, ev_clr;
    always_comb begin
        ev_set = '0;
        ev_set[led_fault_pkg::EV_TYPE1_BIT] = type1 && (state_q == led_fault_pkg::S_RUN);
        ev_set[led_fault_pkg::EV_SHUT_BIT] = shut_hit && (state_q == led_fault_pkg::S_RUN) &&
                                             !type3;
        ev_set[led_fault_pkg::EV_STANDBY_BIT] = type3 &&
                                                (state_q != led_fault_pkg::S_STANDBY);
        ev_set[led_fault_pkg::EV_RESTART_BIT] = do_restart;
        ev_clr = '0;
        if (wr_go && wb_adr_i == led_fault_pkg::EVENT_OFS && wb_sel_i[0]) begin
            ev_clr = wb_dat_i[led_fault_pkg::EV_W-1:0];
        end
    end

    // Event register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_q <= '0;
        end else begin
            event_q <= (event_q & ~ev_clr) | ev_set;
        end
    end

    // Read multiplexer, unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            led_fault_pkg::SHUT_LVL_OFS: rd_mux = {12'h000, shut_lvl_q};
            led_fault_pkg::CEIL_LVL_OFS: rd_mux = {12'h000, ceil_lvl_q};
            led_fault_pkg::RESTART_LVL_OFS: rd_mux = {12'h000, restart_lvl_q};
            led_fault_pkg::LEVEL_OFS: rd_mux = {12'h000, level_q};
            led_fault_pkg::EVENT_OFS: rd_mux = {28'h000_0000, event_q};
            led_fault_pkg::STATUS_OFS: begin
                rd_mux[led_fault_pkg::ST_TYPE1_BIT] = type1;
                rd_mux[led_fault_pkg::ST_TYPE2_BIT] = type2;
                rd_mux[led_fault_pkg::ST_TYPE3_BIT] = type3;
                rd_mux[led_fault_pkg::ST_SHUT_BIT] = shutdown_o;
                rd_mux[led_fault_pkg::ST_STANDBY_BIT] = standby_o;
                rd_mux[led_fault_pkg::ST_AUTO_BIT] = auto_q;
                rd_mux[led_fault_pkg::ST_CATH_BIT] = cath_q;
                rd_mux[led_fault_pkg::ST_STATE_LSB +: 3] = state_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Wishbone ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req && !ack_q;
            if (bus_req && !ack_q) begin
                rdat_q <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

endmodule // led_fault_supervisor

/* led_fault_pkg.sv */
// Constants, register map and state type of the LED fault supervisor
package led_fault_pkg;

    // Clock period in nanoseconds
    localparam int CLK_NS = 8;

    // Blanking after each LED turn-on, as a least time
    localparam int BLANK_NS = 1600;
    // Blanking in clock cycles, rounded up
    localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    // Blanking counter width
    localparam int BLANK_W = 8;

    // Delay ramp level width
    localparam int LVL_W = 20;
    // Source current into the delay node, in tenths of a microamp
    localparam logic [LVL_W-1:0] CHARGE_STEP = 20'h0023a;
    // Sink current out of the delay node, in tenths of a microamp
    localparam logic [LVL_W-1:0] SINK_STEP = 20'h00012;
    // Reset shutdown level (2800 mV, ten units per millivolt)
    localparam logic [LVL_W-1:0] SHUT_LVL_RST = 20'h06d60;
    // Reset ceiling level (3600 mV)
    localparam logic [LVL_W-1:0] CEIL_LVL_RST = 20'h08ca0;
    // Reset restart level (350 mV)
    localparam logic [LVL_W-1:0] RESTART_LVL_RST = 20'h00dac;

    // Register byte offsets
    localparam logic [7:0] SHUT_LVL_OFS = 8'h00;
    localparam logic [7:0] CEIL_LVL_OFS = 8'h04;
    localparam logic [7:0] RESTART_LVL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] LEVEL_OFS = 8'h10;
    localparam logic [7:0] EVENT_OFS = 8'h14;

    // Status register field positions
    localparam int ST_TYPE1_BIT = 0;
    localparam int ST_TYPE2_BIT = 1;
    localparam int ST_TYPE3_BIT = 2;
    localparam int ST_SHUT_BIT = 3;
    localparam int ST_STANDBY_BIT = 4;
    localparam int ST_AUTO_BIT = 5;
    localparam int ST_CATH_BIT = 6;
    localparam int ST_STATE_LSB = 8;

    // Event register field positions
    localparam int EV_TYPE1_BIT = 0;
    localparam int EV_SHUT_BIT = 1;
    localparam int EV_STANDBY_BIT = 2;
    localparam int EV_RESTART_BIT = 3;
    localparam int EV_W = 4;

    // Number of pin inputs through the synchroniser
    localparam int NIN = 12;

    // Supervisor states
    typedef enum logic [2:0] {
        S_STANDBY,
        S_RUN,
        S_SHUT,
        S_AUTO_WAIT,
        S_AUTO_DIS
    } sup_state_e;

endpackage

/* led_fault_props.sv */
// Port-level assertions for the LED fault supervisor
`timescale 1ns/1ps
module led_fault_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_undervoltage_lockout_i,
    input wire logic delay_grounded_i,
    input wire logic shutdown_o,
    input wire logic standby_o,
    input wire logic restart_o,
    input wire logic delay_charge_o,
    input wire logic delay_discharge_o,
    input wire logic short_clamp_o,
    input wire logic [19:0] delay_level_o
);
    // One clock domain, reset masks every check
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_lockout_standby: assert property (supply_undervoltage_lockout_i [*8] |-> standby_o)
        else $error("no standby under lockout");
    chk_standby_idle: assert property (standby_o |-> !delay_charge_o && !shutdown_o)
        else $error("charge or shutdown in standby");
    chk_standby_empty: assert property (standby_o && $past(standby_o) |-> delay_level_o == 20'h0)
        else $error("delay not cleared in standby");
    chk_ground_noshut: assert property (delay_grounded_i [*8] |-> !$rose(shutdown_o))
        else $error("shutdown with grounded delay");
    chk_ground_level: assert property (delay_grounded_i [*8] |-> delay_level_o == 20'h0)
        else $error("grounded delay not zero");
    chk_discharge_falls: assert property (delay_discharge_o |=> delay_level_o <= $past(delay_level_o))
        else $error("delay rose while discharging");
    chk_restart_pulse: assert property (restart_o |=> !restart_o)
        else $error("restart longer than one cycle");
    chk_shut_exit: assert property ($fell(shutdown_o) |-> ##[0:1] (standby_o || restart_o))
        else $error("shutdown left without standby or restart");
    chk_clamp_running: assert property (short_clamp_o |-> !standby_o && !shutdown_o)
        else $error("clamp while stopped");
    chk_ramp_oneway: assert property (!(delay_charge_o && delay_discharge_o))
        else $error("charge and discharge together");
endmodule // led_fault_props

bind led_fault_supervisor led_fault_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .supply_undervoltage_lockout_i(supply_undervoltage_lockout_i),
    .delay_grounded_i(delay_grounded_i), .shutdown_o(shutdown_o), .standby_o(standby_o),
    .restart_o(restart_o), .delay_charge_o(delay_charge_o),
    .delay_discharge_o(delay_discharge_o), .short_clamp_o(short_clamp_o),
    .delay_level_o(delay_level_o)
);

/* led_fault_comparators.sv */
// Analog comparator model driving the supervisor fault pins
`timescale 1ns/1ps
module led_fault_comparators (
    input wire logic [15:0] short_mv_i,
    input wire logic [15:0] fb_mv_i,
    input wire logic [15:0] cath_mv_i,
    input wire logic [15:0] therm_mv_i,
    output logic short_low_o,
    output logic short_high_o,
    output logic fb_over_o,
    output logic fb_under_o,
    output logic cath_low_o,
    output logic therm_low_o
);
    // Node voltages in millivolts against fixed trip points
    always_comb begin
        short_low_o = (short_mv_i >= 16'h0c1c);
        short_high_o = (short_mv_i >= 16'h1770);
        fb_over_o = (fb_mv_i >= 16'h07d0);
        fb_under_o = (fb_mv_i < 16'h0352);
        cath_low_o = (cath_mv_i < 16'h076c);
        therm_low_o = (therm_mv_i < 16'h04b0);
    end
endmodule // led_fault_comparators

/* led_fault_supervisor_tb.sv */
// Self-checking bench for the LED fault supervisor
`timescale 1ns/1ps
module led_fault_supervisor_tb;
    logic clk_i, rst_i, cyc, stb, we, ack, ssd, aux, gnd, ot, uv, led;
    logic shut, stby, rs, chg, dis, clamp, scl, sch, afo, afu, cfl, thl;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat;
    logic [15:0] short_mv, fb_mv, cath_mv, therm_mv;
    logic [19:0] lvl;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    int n_fail = 0;
    int n_tests = 0;
    int cyc_n = 0;
    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    led_fault_supervisor u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .string_short_sense_low_i(scl), .string_short_sense_high_i(sch),
        .anode_feedback_over_i(afo), .anode_feedback_under_i(afu),
        .cathode_feedback_low_i(cfl), .thermistor_sense_low_i(thl),
        .die_overtemp_shutdown_i(ot), .supply_undervoltage_lockout_i(uv),
        .led_on_i(led), .soft_start_done_i(ssd), .aux_channel_off_i(aux),
        .delay_grounded_i(gnd), .shutdown_o(shut), .standby_o(stby), .restart_o(rs),
        .delay_charge_o(chg), .delay_discharge_o(dis), .short_clamp_o(clamp), .delay_level_o(lvl)
    );
    led_fault_comparators u_cmp (
        .short_mv_i(short_mv), .fb_mv_i(fb_mv), .cath_mv_i(cath_mv), .therm_mv_i(therm_mv),
        .short_low_o(scl), .short_high_o(sch), .fb_over_o(afo), .fb_under_o(afu),
        .cath_low_o(cfl), .therm_low_o(thl)
    );
    // Compare one value and count it
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // Verdict and end of run
    task results;
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Classic Wishbone cycle, read expectations queued as mask and value
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
             input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= w ? d : 32'h0;
        sel <= s;
        if (!w) exp_q.push_back({m, d});
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        bus(1'b0, a, x, m, 4'hf);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, a, d, 32'h0, s);
    endtask
    // Bounded wait for a level or pulse
    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(posedge clk_i);
        check(s, 1'b1);
    endtask
    // Read data checked against the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(rdat & e[63:32], e[31:0]);
        end
    end
    // Hang guard
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        {rst_i, cyc, stb, we, ssd, aux, gnd, ot, uv, led} = 10'h200;
        adr = 8'h0;
        sel = 4'hf;
        dat = 32'h0;
        short_mv = 16'h0;
        fb_mv = 16'h05dc;
        cath_mv = 16'h09c4;
        therm_mv = 16'h07d0;
        void'($urandom(32'h71622691));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_hi(rs, 50);
        rd(led_fault_pkg::SHUT_LVL_OFS, led_fault_pkg::SHUT_LVL_RST, 32'hffffffff);
        rd(led_fault_pkg::CEIL_LVL_OFS, led_fault_pkg::CEIL_LVL_RST, 32'hffffffff);
        rd(led_fault_pkg::RESTART_LVL_OFS, led_fault_pkg::RESTART_LVL_RST, 32'hffffffff);
        rd(led_fault_pkg::STATUS_OFS, 32'h120, 32'h77f);
        wr(8'h18, 32'hffffffff, 4'hf);
        rd(8'h18, 32'h0, 32'hffffffff);
        wr(led_fault_pkg::SHUT_LVL_OFS, 32'h40, 4'h1);
        rd(led_fault_pkg::SHUT_LVL_OFS, 32'h06d40, 32'hffffffff);
        // Single-string fault with blanking after turn-on
        short_mv <= 16'(3100 + $urandom % 2800);
        led <= 1'b1;
        repeat (100) @(posedge clk_i);
        check(chg, 1'b0);
        repeat (150) @(posedge clk_i);
        check(chg, 1'b1);
        check(clamp, 1'b1);
        repeat (100) @(posedge clk_i);
        rd(led_fault_pkg::LEVEL_OFS, led_fault_pkg::CEIL_LVL_RST, 32'hfffff);
        check(lvl, led_fault_pkg::CEIL_LVL_RST);
        rd(led_fault_pkg::STATUS_OFS, 32'h1, 32'h9);
        short_mv <= 16'h0;
        repeat (10) @(posedge clk_i);
        check(dis, 1'b1);
        led <= 1'b0;
        repeat (10) @(posedge clk_i);
        check({chg, dis}, 2'b00);
        led <= 1'b1;
        repeat (250) @(posedge clk_i);
        check(dis, 1'b1);
        // Each standby source, then restart
        for (int k = 0; k < 3; k++) begin
            if (k == 0) therm_mv <= 16'h03e8;
            if (k == 1) ot <= 1'b1;
            if (k == 2) uv <= 1'b1;
            repeat (12) @(posedge clk_i);
            check({stby, chg}, 2'b10);
            rd(led_fault_pkg::LEVEL_OFS, 32'h0, 32'hfffff);
            therm_mv <= 16'h07d0;
            ot <= 1'b0;
            uv <= 1'b0;
            wait_hi(rs, 50);
        end
        // Short ramps for the shutdown faults in auto-restart mode
        wr(led_fault_pkg::SHUT_LVL_OFS, 32'h240, 4'hf);
        wr(led_fault_pkg::RESTART_LVL_OFS, 32'h100, 4'hf);
        wr(led_fault_pkg::EVENT_OFS, 32'hf, 4'h1);
        for (int k = 0; k < 4; k++) begin
            if (k == 0) fb_mv <= 16'h0834;
            if (k == 1) {led, fb_mv} <= {1'b0, 16'h02bc};
            if (k == 2) short_mv <= 16'(6000 + $urandom % 2000);
            if (k == 3) begin
                cath_mv <= 16'h05dc;
                repeat (8) @(posedge clk_i);
                ssd <= 1'b1;
                @(posedge clk_i);
                cath_mv <= 16'h09c4;
            end
            wait_hi(shut, 300);
            if (k == 0) begin
                repeat (20) @(posedge clk_i);
                rd(led_fault_pkg::LEVEL_OFS, 32'h240, 32'hfffff);
                check(lvl, 20'h00240);
            end
            fb_mv <= 16'h05dc;
            short_mv <= 16'h0;
            ssd <= 1'b0;
            led <= 1'b1;
            wait_hi(rs, 300);
        end
        rd(led_fault_pkg::EVENT_OFS, 32'ha, 32'ha);
        // Grounded delay node blocks shutdown
        gnd <= 1'b1;
        fb_mv <= 16'h0834;
        repeat (200) @(posedge clk_i);
        check(shut, 1'b0);
        check(lvl, 20'h0);
        rd(led_fault_pkg::LEVEL_OFS, 32'h0, 32'hfffff);
        fb_mv <= 16'h05dc;
        gnd <= 1'b0;
        // Latched shutdown with the aux pin high at startup
        uv <= 1'b1;
        aux <= 1'b1;
        repeat (12) @(posedge clk_i);
        uv <= 1'b0;
        wait_hi(rs, 50);
        rd(led_fault_pkg::STATUS_OFS, 32'h0, 32'h20);
        fb_mv <= 16'h0834;
        wait_hi(shut, 300);
        fb_mv <= 16'h05dc;
        repeat (60) @(posedge clk_i);
        check(shut, 1'b1);
        rd(led_fault_pkg::STATUS_OFS, 32'h208, 32'h728);
        rd(led_fault_pkg::LEVEL_OFS, led_fault_pkg::CEIL_LVL_RST, 32'hfffff);
        uv <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(stby, 1'b1);
        uv <= 1'b0;
        wait_hi(rs, 50);
        results();
    end
endmodule // led_fault_supervisor_tb
